/* rtl/ssm_core.sv */
// Purpose: serial control and mode core of a four-channel switch
// Assumes: fault flags and duty waveform come from ref_clk logic
// Notes: pins from outside pass two flip-flops before use

`timescale 1ns/10ps

module ssm_core import ssm_pkg::*; #(
    parameter int WDOG_CYCLES = WDOG_TIMEOUT_CYCLES,
    parameter int HOLD_CYCLES = DIR_HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ssm_spi_pins_t spi_pins,
    output logic so,
    output logic so_oe,
    input wire logic [3:0] in_pins,
    input wire logic wake_rst_pin,
    input wire logic wake_pin,
    input wire logic failsafe_select_input,
    input wire logic vdd_fail_pin,
    input wire ssm_fault_t faults,
    input wire logic [3:0] duty_wave,
    output logic [3:0] power_output_channel,
    output logic [3:0] fault_clear,
    output logic normal_mode_flag,
    output ssm_mode_t mode
);

    // ========================================
    // declarations
    logic [3:0] pin_meta_r, pin_sync_r;
    logic [3:0] in_level, in_req;
    logic frame_valid;
    ssm_frame_t frame;
    logic [15:0] status;
    logic [3:0] on_r, block_r;
    logic [2:0] cfg_r;
    logic wd_last_r, wd_to_r, wd_hit, wd_en, wd_toggle;
    logic [31:0] wd_cnt_r;
    logic wake, fail, fault, fsi_open;
    logic [3:0] ch_fault;
    logic global_fault;
    logic [3:0] on_eff, block_eff;
    logic pwm_en, vdd_fail_en, hs_gate;
    logic [3:0] hs_nxt, clr_nxt;
    ssm_mode_t mode_nxt;

    // ========================================
    // mode decode
    function automatic ssm_mode_t pick_mode(input logic w, input logic f,
                                           input logic flt);
        if (!w) begin
            pick_mode = SSM_SLEEP;
        end else if (flt) begin
            pick_mode = SSM_FAULT;
        end else if (f) begin
            pick_mode = SSM_FAILSAFE;
        end else begin
            pick_mode = SSM_NORMAL;
        end
    endfunction

    // ========================================
    // serial link
    ssm_spi_link u_link (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins(spi_pins),
        .status(status),
        .frame_valid(frame_valid),
        .frame(frame),
        .so(so),
        .so_oe(so_oe)
    );

    // ========================================
    // direct ports
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_dir
            ssm_dir_qual #(
                .HOLD_CYCLES(HOLD_CYCLES)
            ) u_dir (
                .ref_clk(ref_clk),
                .reset(reset),
                .pin(in_pins[gi]),
                .level(in_level[gi]),
                .request(in_req[gi])
            );
        end
    endgenerate

    // ========================================
    // control pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_r <= PINS_IDLE;
            pin_sync_r <= PINS_IDLE;
        end else begin
            pin_meta_r <= {wake_rst_pin, wake_pin, failsafe_select_input,
                           vdd_fail_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign fsi_open = pin_sync_r[PIN_FSI];
    assign wd_en = fsi_open;

    // ========================================
    // wake, fail and fault terms
    assign wake = pin_sync_r[PIN_WAKE_RST] | pin_sync_r[PIN_WAKE]
                | (|in_req);

    // sleep forces every serial setting to read as zero
    assign on_eff = (mode == SSM_SLEEP) ? CH_RESET : on_r;
    assign block_eff = (mode == SSM_SLEEP) ? CH_RESET : block_r;
    assign pwm_en = cfg_r[CFG_PWM_EN] && (mode != SSM_SLEEP);
    assign vdd_fail_en = cfg_r[CFG_VDD_FAIL_EN] && (mode != SSM_SLEEP);
    assign hs_gate = cfg_r[CFG_HS_GATE] && (mode != SSM_SLEEP);

    assign fail = (pin_sync_r[PIN_VDD_FAIL] & vdd_fail_en)
                | (wd_to_r & fsi_open);

    assign ch_fault = faults.overcurrent_flag | faults.overtemp_flag
                    | faults.severe_short_flag;
    assign global_fault = faults.undervoltage_flag
                        | (faults.high_supply_flag & hs_gate);
    assign fault = (|ch_fault) | global_fault;

    assign mode_nxt = pick_mode(wake, fail, fault);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode <= SSM_SLEEP;
            normal_mode_flag <= 1'b0;
        end else begin
            mode <= mode_nxt;
            normal_mode_flag <= (mode_nxt == SSM_NORMAL);
        end
    end

    // ========================================
    // configuration registers
    // supply-fail enable survives fail-safe, else the mode would chatter
    always_ff @(posedge ref_clk) begin
        if (reset || mode == SSM_SLEEP) begin
            on_r <= CH_RESET;
            block_r <= CH_RESET;
            cfg_r <= CFG_RESET;
        end else if (mode == SSM_FAILSAFE) begin
            on_r <= CH_RESET;
            block_r <= CH_RESET;
            cfg_r[CFG_PWM_EN] <= 1'b0;
            cfg_r[CFG_HS_GATE] <= 1'b0;
        end else if (frame_valid) begin
            case (frame.addr)
                ADDR_ON: begin
                    on_r <= frame.data[3:0];
                end
                ADDR_PATH_BLOCK: begin
                    block_r <= frame.data[3:0];
                end
                ADDR_CONFIG: begin
                    cfg_r <= frame.data[2:0];
                end
                default: begin
                    on_r <= on_r;
                end
            endcase
        end
    end

    // ========================================
    // watchdog
    assign wd_toggle = frame_valid && (frame.wd != wd_last_r);
    assign wd_hit = wd_en && (mode == SSM_NORMAL)
                  && (wd_cnt_r == 32'(WDOG_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (reset || mode == SSM_SLEEP) begin
            wd_cnt_r <= '0;
        end else if (!wd_en || mode != SSM_NORMAL || wd_toggle || wd_hit) begin
            wd_cnt_r <= '0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 32'd1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || mode == SSM_SLEEP) begin
            wd_last_r <= 1'b0;
        end else if (frame_valid) begin
            wd_last_r <= frame.wd;
        end
    end

    // timeout set wins over a clearing frame in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset || mode == SSM_SLEEP) begin
            wd_to_r <= 1'b0;
        end else if (!wd_en) begin
            wd_to_r <= 1'b0;
        end else if (wd_hit) begin
            wd_to_r <= 1'b1;
        end else if (frame_valid && frame.wd) begin
            wd_to_r <= 1'b0;
        end
    end

    // ========================================
    // output drive and fault-clear trigger
    always_comb begin
        hs_nxt = 4'h0;
        clr_nxt = 4'h0;
        for (int i = 0; i < CHANNELS; i++) begin
            case (mode)
                SSM_SLEEP: begin
                    hs_nxt[i] = 1'b0;
                end
                SSM_FAILSAFE: begin
                    hs_nxt[i] = in_level[i];
                end
                SSM_NORMAL, SSM_FAULT: begin
                    hs_nxt[i] = (((in_level[i] & ~block_eff[i]) | on_eff[i])
                                 & ~pwm_en)
                              | (on_eff[i] & duty_wave[i] & pwm_en);
                    if (mode == SSM_FAULT
                        && (ch_fault[i] || global_fault)) begin
                        hs_nxt[i] = 1'b0;
                    end
                end
                default: begin
                    hs_nxt[i] = 1'b0;
                end
            endcase
            if (mode == SSM_NORMAL || mode == SSM_FAILSAFE) begin
                clr_nxt[i] = ((in_req[i] & ~block_eff[i]) & ~pwm_en)
                           | on_eff[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            power_output_channel <= 4'h0;
            fault_clear <= 4'h0;
        end else begin
            power_output_channel <= hs_nxt;
            fault_clear <= clr_nxt;
        end
    end

    // ========================================
    // status word loaded at chip select fall
    assign status = {normal_mode_flag, fail, fault, wake,
                     faults.undervoltage_flag, faults.high_supply_flag,
                     2'b00, ch_fault, power_output_channel};

endmodule

/* rtl/ssm_pkg.sv */
// Purpose: shared constants and types of the switch serial/mode core
// Assumes: core clock of 100 MHz
// Notes: frame layout and register addresses are defined here only

package ssm_pkg;

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIR_HOLD_NS = 2000;
    // least time, so rounded up to whole cycles
    localparam int DIR_HOLD_CYCLES =
        (DIR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDOG_TIMEOUT_CYCLES = 1000000;

    // ========================================
    // frame layout
    localparam int CHANNELS = 4;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 10;
    localparam logic [4:0] FRAME_CNT = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h1f;

    // ========================================
    // register addresses and fields
    localparam logic [4:0] ADDR_ON = 5'h00;
    localparam logic [4:0] ADDR_PATH_BLOCK = 5'h01;
    localparam logic [4:0] ADDR_CONFIG = 5'h02;
    localparam int CFG_PWM_EN = 0;
    localparam int CFG_VDD_FAIL_EN = 1;
    localparam int CFG_HS_GATE = 2;
    localparam logic [3:0] CH_RESET = 4'h0;
    localparam logic [2:0] CFG_RESET = 3'h0;

    // ========================================
    // pin synchroniser order and idle values
    localparam int PIN_WAKE_RST = 3;
    localparam int PIN_WAKE = 2;
    localparam int PIN_FSI = 1;
    localparam int PIN_VDD_FAIL = 0;
    localparam logic [3:0] PINS_IDLE = 4'h0;
    localparam logic [2:0] SPI_IDLE = 3'h2;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        SSM_SLEEP = 2'b00,
        SSM_NORMAL = 2'b01,
        SSM_FAILSAFE = 2'b10,
        SSM_FAULT = 2'b11
    } ssm_mode_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic si;
    } ssm_spi_pins_t;

    typedef struct packed {
        logic wd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ssm_frame_t;

    typedef struct packed {
        logic [3:0] overcurrent_flag;
        logic [3:0] overtemp_flag;
        logic [3:0] severe_short_flag;
        logic undervoltage_flag;
        logic high_supply_flag;
    } ssm_fault_t;

endpackage

/* rtl/ssm_spi_link.sv */
// Purpose: 16-bit serial slave, sampled by the core clock
// Assumes: sclk idles low while chip select is high
// Notes: edges are found after a two-stage synchroniser

`timescale 1ns/10ps

module ssm_spi_link import ssm_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ssm_spi_pins_t pins,
    input wire logic [15:0] status,
    output logic frame_valid,
    output ssm_frame_t frame,
    output logic so,
    output logic so_oe
);

    // ========================================
    // synchronisers and edges
    ssm_spi_pins_t meta_r, sync_r, prev_r;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall, active;
    logic [15:0] rx_r, tx_r;
    logic [4:0] cnt_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= SPI_IDLE;
            sync_r <= SPI_IDLE;
            prev_r <= SPI_IDLE;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign sclk_rise = sync_r.sclk & ~prev_r.sclk;
    assign sclk_fall = ~sync_r.sclk & prev_r.sclk;
    assign cs_fall = ~sync_r.cs_n & prev_r.cs_n;
    assign cs_rise = sync_r.cs_n & ~prev_r.cs_n;
    // clock and data are dead while deselected
    assign active = ~sync_r.cs_n & ~prev_r.cs_n;

    // ========================================
    // receive
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_r <= WORD_ZERO;
            cnt_r <= '0;
        end else if (cs_fall) begin
            cnt_r <= '0;
        end else if (active && sclk_fall) begin
            rx_r <= {rx_r[14:0], sync_r.si};
            if (cnt_r != CNT_MAX) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // a frame of any other length is dropped whole
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            frame_valid <= 1'b0;
            frame <= WORD_ZERO;
        end else begin
            frame_valid <= cs_rise && (cnt_r == FRAME_CNT);
            if (cs_rise) begin
                frame <= rx_r;
            end
        end
    end

    // ========================================
    // transmit
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_r <= WORD_ZERO;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else if (cs_fall) begin
            tx_r <= status;
            so <= status[15];
            so_oe <= 1'b1;
        end else if (cs_rise) begin
            so <= 1'b0;
            so_oe <= 1'b0;
        end else if (active && sclk_rise) begin
            so <= tx_r[15];
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

endmodule

/* rtl/ssm_dir_qual.sv */
// Purpose: synchronise one direct drive pin and qualify it
// Assumes: pin is asynchronous to ref_clk
// Notes: request stays up HOLD_CYCLES after the pin falls

`timescale 1ns/10ps

module ssm_dir_qual #(
    parameter int HOLD_CYCLES = 200
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin,
    output logic level,
    output logic request
);

    localparam int W = $clog2(HOLD_CYCLES + 1);

    logic meta_r, sync_r;
    logic [W-1:0] hold_r;

    // ========================================
    // synchroniser and hold
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
        end
    end

    // hold bridges short gaps so pwm on the pin does not sleep the part
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_r <= '0;
            level <= 1'b0;
            request <= 1'b0;
        end else begin
            if (sync_r) begin
                hold_r <= W'(HOLD_CYCLES);
            end else if (hold_r != '0) begin
                hold_r <= hold_r - W'(1);
            end
            level <= sync_r;
            request <= sync_r | (hold_r != '0);
        end
    end

endmodule

/* verification/ssm_core_chk.sv */
// Purpose: port checks of the switch serial/mode core
// Assumes: bound to ssm_core, one clock domain
// Notes: latencies allow for the two-stage pin synchronisers
`timescale 1ns/10ps
module ssm_core_chk import ssm_pkg::*; #(
    parameter int HOLD_CYCLES = DIR_HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ssm_spi_pins_t spi_pins,
    input wire logic so,
    input wire logic so_oe,
    input wire logic [3:0] in_pins,
    input wire logic wake_rst_pin,
    input wire logic wake_pin,
    input wire ssm_fault_t faults,
    input wire logic [3:0] power_output_channel,
    input wire logic [3:0] fault_clear,
    input wire logic normal_mode_flag,
    input wire ssm_mode_t mode
);
    // ========
    // helpers
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    int idle_r;
    logic [3:0] chf;
    logic flt;
    assign chf = faults.overcurrent_flag | faults.overtemp_flag
        | faults.severe_short_flag;
    assign flt = (|chf) | faults.undervoltage_flag;
    // counter, since the hold time is far beyond a repetition
    always_ff @(posedge ref_clk) begin
        if (reset || wake_rst_pin || wake_pin || (|in_pins)) begin
            idle_r <= 0;
        end else if (idle_r < 4000) begin
            idle_r <= idle_r + 1;
        end
    end
    sequence s_cs_idle;
        spi_pins.cs_n [*6];
    endsequence
    sequence s_fs_steady;
        (mode == SSM_FAILSAFE && $stable(in_pins)) [*6];
    endsequence
    sequence s_fault_held;
        ((wake_rst_pin || wake_pin) && flt) [*5];
    endsequence
    // ========
    // assertions
    a_so_released: assert property (s_cs_idle |-> !so_oe)
        else $error("serial output driven while deselected");
    a_so_enable: assert property (
        $fell(spi_pins.cs_n) |-> ##[2:6] so_oe)
        else $error("serial output not enabled after select");
    a_so_quiet: assert property (!so_oe |-> !so)
        else $error("serial output data while released");
    a_nm_set: assert property (
        $past(mode) == SSM_NORMAL && mode == SSM_NORMAL |-> normal_mode_flag)
        else $error("normal flag low in normal mode");
    a_nm_clear: assert property (
        (mode != SSM_NORMAL) [*2] |-> !normal_mode_flag)
        else $error("normal flag high outside normal mode");
    a_sleep_off: assert property (
        (mode == SSM_SLEEP) [*2] |-> power_output_channel == 4'h0)
        else $error("output on in sleep");
    a_wake_sleep: assert property (
        idle_r > HOLD_CYCLES + 8 |-> mode == SSM_SLEEP)
        else $error("awake with every wake source low");
    a_wake_up: assert property (
        (wake_rst_pin || wake_pin) [*6] |-> mode != SSM_SLEEP)
        else $error("asleep with a wake pin high");
    a_fault_mode: assert property (
        s_fault_held |-> mode == SSM_FAULT)
        else $error("fault term without fault mode");
    a_fault_off: assert property ((mode == SSM_FAULT) [*3] |->
        (power_output_channel & chf & $past(chf) & $past(chf, 2)) == 4'h0)
        else $error("faulted channel driven");
    a_fs_follow: assert property (
        s_fs_steady |-> power_output_channel == in_pins)
        else $error("fail-safe output not following its port");
    a_fc_zero: assert property (
        (mode == SSM_SLEEP || mode == SSM_FAULT) [*2] |-> fault_clear == 4'h0)
        else $error("fault clear outside normal and fail-safe");
endmodule

/* verification/ssm_host_model.sv */
// Purpose: serial master standing in for the host controller
// Assumes: called at a falling ref_clk edge
// Notes: half gives the serial half period in core cycles
`timescale 1ns/10ps
module ssm_host_model import ssm_pkg::*; (
    input wire logic ref_clk,
    input wire logic so,
    input wire logic so_oe,
    output ssm_spi_pins_t pins
);
    // idle is the pull levels: select up, clock and data down
    initial pins = SPI_IDLE;
    task automatic xfer(input logic [31:0] w, input int n, input int half,
                        output logic [31:0] rx, output logic oe);
        rx = 32'h0;
        oe = 1'b1;
        @(negedge ref_clk);
        pins.cs_n = 1'b0;
        repeat (half) @(negedge ref_clk);
        for (int i = n - 1; i >= 0; i--) begin
            pins.sclk = 1'b1;
            pins.si = w[i];
            repeat (half) @(negedge ref_clk);
            pins.sclk = 1'b0;
            rx = {rx[30:0], so};
            oe = oe & so_oe;
            repeat (half) @(negedge ref_clk);
        end
        pins = SPI_IDLE;
        repeat (half) @(negedge ref_clk);
    endtask
    // clock and data wiggle while deselected; the link must not react
    task automatic stray(input int n, input int half);
        for (int i = 0; i < 2 * n; i++) begin
            @(negedge ref_clk);
            pins.sclk = ~pins.sclk;
            pins.si = ~pins.si;
            repeat (half) @(negedge ref_clk);
        end
        pins = SPI_IDLE;
    endtask
endmodule

/* verification/ssm_core_tb.sv */
// Purpose: self-checking bench of the switch serial/mode core
// Assumes: host model drives the serial pins
// Notes: short watchdog and hold counts keep the run brief
`timescale 1ns/10ps
module ssm_core_tb import ssm_pkg::*;;
    localparam int WDOG = 2000;
    localparam int HOLD = 8;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    ssm_spi_pins_t spi_pins;
    logic so;
    logic so_oe;
    logic [3:0] in_pins = 4'h0;
    logic wake_rst_pin = 1'b0;
    logic wake_pin = 1'b0;
    logic failsafe_select_input = 1'b0;
    logic vdd_fail_pin = 1'b0;
    ssm_fault_t faults = '0;
    logic [3:0] duty_wave = 4'h0;
    logic [3:0] power_output_channel;
    logic [3:0] fault_clear;
    logic normal_mode_flag;
    ssm_mode_t mode;
    int err_count = 0;
    int checks = 0;
    int seed = 96;
    int half = 8;
    logic [3:0] on_m = 4'h0;
    logic [3:0] blk_m = 4'h0;
    logic [2:0] cfg_m = 3'h0;
    logic wdto_m = 1'b0;
    logic [15:0] stat_m;
    ssm_mode_t mode_m;

    always #5 ref_clk = ~ref_clk;

    ssm_core #(.WDOG_CYCLES(WDOG), .HOLD_CYCLES(HOLD)) ssm_core_inst (
        .ref_clk, .reset, .spi_pins, .so, .so_oe, .in_pins, .wake_rst_pin,
        .wake_pin, .failsafe_select_input, .vdd_fail_pin, .faults,
        .duty_wave, .power_output_channel, .fault_clear, .normal_mode_flag,
        .mode);
    ssm_host_model ssm_host_model_inst (
        .ref_clk, .so, .so_oe, .pins(spi_pins));

    // ========
    // model and checks
    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] a);
        checks++;
        if (a !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, a);
        end
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    // long enough for synchronisers and the request hold
    task automatic settle();
        repeat (24) @(negedge ref_clk);
    endtask
    task automatic check_all();
        logic [3:0] chf;
        logic [3:0] o;
        logic [3:0] fc;
        logic wk;
        logic fl;
        logic gf;
        logic ft;
        logic pwm;
        chf = faults.overcurrent_flag | faults.overtemp_flag
            | faults.severe_short_flag;
        wk = wake_rst_pin | wake_pin | (|in_pins);
        fl = (vdd_fail_pin & cfg_m[CFG_VDD_FAIL_EN])
            | (wdto_m & failsafe_select_input);
        gf = faults.undervoltage_flag
            | (faults.high_supply_flag & cfg_m[CFG_HS_GATE]);
        ft = (|chf) | gf;
        mode_m = !wk ? SSM_SLEEP : ft ? SSM_FAULT
            : fl ? SSM_FAILSAFE : SSM_NORMAL;
        if (mode_m == SSM_SLEEP || mode_m == SSM_FAILSAFE) begin
            on_m = CH_RESET;
            blk_m = CH_RESET;
            cfg_m = (mode_m == SSM_SLEEP) ? CFG_RESET : cfg_m & 3'h2;
        end
        pwm = cfg_m[CFG_PWM_EN];
        o = (((in_pins & ~blk_m) | on_m) & {4{~pwm}})
            | (on_m & duty_wave & {4{pwm}});
        fc = (in_pins & ~blk_m & {4{~pwm}}) | on_m;
        if (mode_m == SSM_FAULT) begin
            o = gf ? 4'h0 : o & ~chf;
        end
        o = (mode_m == SSM_SLEEP) ? 4'h0 : o;
        fc = (mode_m == SSM_SLEEP || mode_m == SSM_FAULT) ? 4'h0 : fc;
        stat_m = {mode_m == SSM_NORMAL, fl, ft, wk, faults.undervoltage_flag,
                  faults.high_supply_flag, 2'h0, chf, o};
        cmp("mode", 16'(mode_m), 16'(mode));
        cmp("drive", 16'(o), 16'(power_output_channel));
        cmp("clear", 16'(fc), 16'(fault_clear));
        cmp("nm", 16'(mode_m == SSM_NORMAL), 16'(normal_mode_flag));
    endtask
    task automatic send(input logic wd, input logic [4:0] a,
                        input logic [9:0] d, input int n);
        logic [31:0] rx;
        logic oe;
        check_all();
        ssm_host_model_inst.xfer({16'h0, wd, a, d}, n, half, rx, oe);
        if (n == 16) begin
            cmp("status", stat_m, rx[15:0]);
            cmp("so enable", 16'h1, 16'(oe));
            if (wd) begin
                wdto_m = 1'b0;
            end
            if (mode_m == SSM_NORMAL || mode_m == SSM_FAULT) begin
                case (a)
                    ADDR_ON: on_m = d[3:0];
                    ADDR_PATH_BLOCK: blk_m = d[3:0];
                    ADDR_CONFIG: cfg_m = d[2:0];
                    default: ;
                endcase
            end
        end
        settle();
        check_all();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ========
    // scenarios
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        repeat (6) @(negedge ref_clk);
        check_all();
        tend("reset");
        wake_rst_pin = 1'b1;
        settle();
        check_all();
        send(1'b0, ADDR_ON, 10'h005, 16);
        send(1'b0, ADDR_ON, 10'h00a, 15);
        ssm_host_model_inst.stray(4, half);
        send(1'b0, ADDR_ON, 10'h00a, 17);
        send(1'b0, 5'h1f, 10'h3ff, 16);
        tend("frames");
        for (int i = 0; i < 8; i++) begin
            in_pins = 4'($random(seed));
            duty_wave = 4'($random(seed));
            settle();
            send(1'b0, ADDR_PATH_BLOCK, 10'($random(seed)), 16);
            send(1'b0, ADDR_CONFIG, 10'(i % 2), 16);
            send(1'b0, ADDR_ON, 10'($random(seed)), 16);
        end
        tend("drive");
        for (int g = 0; g < 2; g++) begin
            send(1'b0, ADDR_CONFIG, 10'(g * 4), 16);
            for (int k = 0; k < 14; k++) begin
                faults = ssm_fault_t'(14'h1 << k);
                settle();
                send(1'b0, ADDR_ON, 10'($random(seed)), 16);
                faults = '0;
                settle();
                check_all();
            end
        end
        tend("faults");
        vdd_fail_pin = 1'b1;
        in_pins = 4'h9;
        settle();
        send(1'b0, ADDR_ON, 10'h00f, 16);
        send(1'b0, ADDR_CONFIG, 10'h002, 16);
        send(1'b0, ADDR_ON, 10'h003, 16);
        in_pins = 4'h6;
        settle();
        check_all();
        vdd_fail_pin = 1'b0;
        settle();
        check_all();
        tend("supply");
        failsafe_select_input = 1'b1;
        for (int t = 0; t < WDOG + 500 && mode !== SSM_FAILSAFE; t++) begin
            @(negedge ref_clk);
        end
        cmp("watchdog", 16'(SSM_FAILSAFE), 16'(mode));
        if (mode !== SSM_FAILSAFE) begin
            report_and_stop();
        end
        wdto_m = 1'b1;
        settle();
        check_all();
        in_pins = 4'h5;
        settle();
        check_all();
        send(1'b1, ADDR_ON, 10'h00f, 16);
        failsafe_select_input = 1'b0;
        settle();
        check_all();
        tend("watchdog");
        wake_rst_pin = 1'b0;
        in_pins = 4'h0;
        settle();
        send(1'b0, ADDR_ON, 10'h00f, 16);
        in_pins = 4'h2;
        repeat (2) @(negedge ref_clk);
        in_pins = 4'h0;
        repeat (5) @(negedge ref_clk);
        cmp("held wake", 16'(SSM_NORMAL), 16'(mode));
        settle();
        check_all();
        wake_pin = 1'b1;
        settle();
        check_all();
        tend("sleep");
        report_and_stop();
    end
endmodule

bind ssm_core ssm_core_chk #(.HOLD_CYCLES(HOLD_CYCLES)) ssm_core_chk_inst (
    .ref_clk, .reset, .spi_pins, .so, .so_oe, .in_pins, .wake_rst_pin,
    .wake_pin, .faults, .power_output_channel, .fault_clear,
    .normal_mode_flag, .mode);
